// ### testbench/bmi_ctl_model.sv
// Bus controller model: addresses the interpreter, sends messages, reads talker bytes.
// Assumes the bench calls its tasks and that it shares the interpreter clock.
`timescale 1ns/1ps
module bmi_ctl_model
  import bmi_pkg::*;
(
  input wire logic clk_in,
  output logic rx_valid_out,
  output bmi_rx_s rx_out,
  input wire logic rx_ready_in,
  input wire logic tx_valid_in,
  input wire bmi_tx_s tx_in,
  output logic tx_ready_out
);
  // Unbounded, so a long settings answer always fits.
  bmi_tx_s got_q[$];
  int slow;

  initial begin
    rx_valid_out = 1'b0;
    rx_out = '0;
    tx_ready_out = 1'b0;
    slow = 0;
  end

  // Byte held from a falling edge until the rising edge that takes it.
  task automatic put(input logic [7:0] b, input logic eoi, input logic atn);
    int n;
    @(negedge clk_in);
    rx_out = '{data: b, eoi: eoi, atn: atn};
    rx_valid_out = 1'b1;
    n = 0;
    while (!(atn || rx_ready_in) && n < 2000) begin
      @(negedge clk_in);
      n++;
    end
    @(negedge clk_in);
    rx_valid_out = 1'b0;
    // A released bus must not keep showing the last byte.
    rx_out = ~rx_out;
  endtask

  // Listen address, message bytes, terminator, then unlisten.
  task automatic send_msg(input logic [7:0] la, input string s, input logic by_eoi);
    put(la, 1'b0, 1'b1);
    for (int i = 0; i < s.len(); i++) begin
      put(s[i], by_eoi && (i == s.len() - 1), 1'b0);
    end
    if (!by_eoi) put(BMI_LF, 1'b0, 1'b0);
    put(BMI_UNL, 1'b0, 1'b1);
  endtask

  // Talk address, then bytes until one carries EOI, then untalk.
  task automatic read_msg(input logic [7:0] ta);
    int n;
    got_q.delete();
    put(ta, 1'b0, 1'b1);
    n = 0;
    while (n < 3000) begin
      @(negedge clk_in);
      n++;
      if (tx_valid_in === 1'b1) begin
        repeat (slow) @(negedge clk_in);
        got_q.push_back(tx_in);
        tx_ready_out = 1'b1;
        @(negedge clk_in);
        tx_ready_out = 1'b0;
        if (got_q[$].eoi === 1'b1) break;
      end
    end
    put(8'h5F, 1'b0, 1'b1);
  endtask
endmodule // bmi_ctl_model

// ### testbench/bmi_interp_test.sv
// Self-checking bench for the bus message interpreter.
// Assumes bmi_ctl_model plays the bus controller; an instrument is modelled here.
`timescale 1ns/1ps
module bmi_interp_test;
  import bmi_pkg::*;
  logic clk, srst, ren, rx_valid, rx_ready, listen, talk, cmd_valid, cmd_end;
  logic exec, tx_valid, tx_ready, srq;
  logic cls_alters = 1'b0;
  logic ans_valid = 1'b0;
  logic done = 1'b0;
  logic [4:0] sw;
  logic [7:0] nm, op;
  logic [7:0] ans_byte = 8'h00;
  logic [7:0] val = 8'h30;
  logic [6:0] ev;
  logic is_q;
  bmi_rx_s rx;
  bmi_cmd_s cmd;
  bmi_tx_s tx;
  logic [7:0] unit[$];
  int num_errors, total_checks, num_exec, cycles, learn_n;

  bmi_interp i_dut (.clk_in(clk), .srst_in(srst), .addr_sw_in(sw), .ren_in(ren),
    .rx_valid_in(rx_valid), .rx_in(rx), .rx_ready_out(rx_ready), .listen_out(listen),
    .talk_out(talk), .cmd_valid_out(cmd_valid), .cmd_out(cmd), .cmd_end_out(cmd_end),
    .cls_alters_in(cls_alters), .exec_out(exec), .ans_valid_in(ans_valid),
    .ans_byte_in(ans_byte), .done_in(done), .tx_valid_out(tx_valid), .tx_out(tx),
    .tx_ready_in(tx_ready), .srq_out(srq), .event_code_out(ev));
  bmi_ctl_model i_ctl (.clk_in(clk), .rx_valid_out(rx_valid), .rx_out(rx),
    .rx_ready_in(rx_ready), .tx_valid_in(tx_valid), .tx_in(tx), .tx_ready_out(tx_ready));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Instrument: "Vd" sets a digit, "V?" answers it, "S?" answers the two-byte learn
  // string one byte a cycle; any other unit just completes.
  always @(negedge clk) begin
    ans_valid = 1'b0;
    done = 1'b0;
    if (learn_n > 0) begin
      ans_valid = 1'b1;
      ans_byte = (learn_n == 2) ? "V" : val;
      learn_n--;
      done = (learn_n == 0);
    end
    if (cmd_valid === 1'b1) unit.push_back(cmd.data);
    if (cmd_end === 1'b1) begin
      is_q = cmd.query;
      nm = (unit.size() > 0) ? unit[0] : 8'h00;
      op = (unit.size() > 1) ? unit[1] : 8'h00;
      cls_alters = (nm == "V") && !cmd.query;
      unit.delete();
    end
    if (exec === 1'b1) begin
      num_exec++;
      if (nm == "V" && is_q) begin
        ans_valid = 1'b1;
        ans_byte = val;
      end else if (nm == "V") begin
        val = op;
      end
      learn_n = (nm == "S" && is_q) ? 2 : 0;
      done = (learn_n == 0);
    end
  end

  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      give_verdict();
    end
  end

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    chk_byte({7'h00, got}, {7'h00, exp}, what);
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    while (rx_ready !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
  endtask

  function automatic logic [7:0] la();
    return BMI_LISTEN_BASE + {3'h0, sw};
  endfunction

  task automatic expect_ans(input string s);
    int last;
    wait_idle();
    i_ctl.read_msg(BMI_TALK_BASE + {3'h0, sw});
    last = s.len() - 1;
    chk_byte(8'(i_ctl.got_q.size()), 8'(s.len()), "answer length");
    for (int i = 0; i < s.len() && i < i_ctl.got_q.size(); i++) begin
      chk_byte(i_ctl.got_q[i].data, s[i], "answer byte");
      chk_bit(i_ctl.got_q[i].eoi, i == last, "answer eoi");
    end
  endtask

  task automatic t_addr;
    i_ctl.put(la(), 1'b0, 1'b1);
    chk_bit(listen, 1'b1, "listen on own address");
    i_ctl.put(BMI_UNL, 1'b0, 1'b1);
    i_ctl.put(la() + 8'h01, 1'b0, 1'b1);
    chk_bit(listen, 1'b0, "listen on other address");
    expect_ans("\377");
    chk_bit(talk, 1'b0, "talk after untalk");
    sw = 5'h1F;
    i_ctl.put(BMI_LISTEN_BASE + 8'h1E, 1'b0, 1'b1);
    chk_bit(listen, 1'b1, "switch clamped to 30");
    i_ctl.put(BMI_UNL, 1'b0, 1'b1);
    sw = 5'h01;
  endtask

  // Message without a terminator must sit unexecuted; queries see earlier units only.
  task automatic t_order;
    int n0;
    string m;
    n0 = num_exec;
    m = "V3;V?";
    i_ctl.put(la(), 1'b0, 1'b1);
    for (int i = 0; i < m.len(); i++) i_ctl.put(m[i], 1'b0, 1'b0);
    repeat (30) @(negedge clk);
    chk_byte(8'(num_exec - n0), 8'h00, "ran before terminator");
    i_ctl.put(BMI_LF, 1'b0, 1'b0);
    i_ctl.put(BMI_UNL, 1'b0, 1'b1);
    wait_idle();
    chk_byte(8'(num_exec - n0), 8'h02, "units run");
    i_ctl.send_msg(la(), "V1;V?;V2;V?", 1'b0);
    i_ctl.slow = 3;
    expect_ans("1;2");
    i_ctl.slow = 0;
    expect_ans("\377");
    i_ctl.send_msg(la(), "V5;V?", 1'b1);
    expect_ans("5");
  endtask

  task automatic t_ren;
    int n0;
    ren = 1'b0;
    n0 = num_exec;
    i_ctl.send_msg(la(), "V7;V?", 1'b0);
    wait_idle();
    chk_byte(8'(num_exec - n0), 8'h01, "only query ran");
    chk_bit(srq, 1'b1, "service request");
    chk_byte({1'b0, ev}, {1'b0, BMI_EV_LOCKED}, "event code");
    expect_ans("5");
    i_ctl.send_msg(la(), "EVENT?", 1'b0);
    expect_ans($sformatf("%0d", BMI_EV_LOCKED));
    chk_bit(srq, 1'b0, "request cleared");
    ren = 1'b1;
  endtask

  // More bytes than the input store holds: the excess is dropped and reported.
  task automatic t_overrun;
    string m;
    m = "";
    repeat (66) m = {m, ";"};
    i_ctl.send_msg(la(), m, 1'b0);
    wait_idle();
    chk_bit(srq, 1'b1, "overrun request");
    chk_byte({1'b0, ev}, {1'b0, BMI_EV_OVERRUN}, "overrun code");
    i_ctl.send_msg(la(), "EVENT?", 1'b0);
    expect_ans($sformatf("%0d", BMI_EV_OVERRUN));
    chk_bit(srq, 1'b0, "overrun request cleared");
  endtask

  // Learn string round trip: the answer, sent back unchanged, restores the setting.
  task automatic t_learn;
    string m;
    i_ctl.send_msg(la(), "S?", 1'b1);
    expect_ans("V5");
    m = "xx";
    for (int i = 0; i < 2 && i < i_ctl.got_q.size(); i++) m[i] = i_ctl.got_q[i].data;
    i_ctl.send_msg(la(), "V9", 1'b0);
    i_ctl.send_msg(la(), m, 1'b0);
    i_ctl.send_msg(la(), "V?", 1'b0);
    expect_ans("5");
  endtask

  initial begin
    srst = 1'b1;
    ren = 1'b1;
    sw = 5'h01;
    repeat (16) @(negedge clk);
    srst = 1'b0;
    repeat (2) @(negedge clk);
    t_addr();
    t_order();
    t_ren();
    t_overrun();
    t_learn();
    give_verdict();
  end
endmodule // bmi_interp_test

// ### verilog/bmi_byte_store.sv
// Flip-flop byte storage with one write port and one combinational read.
// Assumes the caller keeps the write index inside the depth.
`timescale 1ns/1ps
module bmi_byte_store
  import bmi_pkg::*;
(
  input wire logic clk_in,
  input wire logic we_in,
  input wire logic [5:0] waddr_in,
  input wire logic [7:0] wdata_in,
  input wire logic [5:0] raddr_in,
  output logic [7:0] rdata_out
);
  logic [7:0] mem_q [64];
  logic [7:0] mem_d [64];

  always_comb begin
    mem_d = mem_q;
    if (we_in) begin
      mem_d[waddr_in] = wdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    mem_q <= mem_d;
  end

  assign rdata_out = mem_q[raddr_in];
endmodule // bmi_byte_store

// ### verilog/bmi_interp.sv
// Bus message interpreter: addressing, message split, ordered execution, answers.
// Assumes a handshake layer delivering bus bytes and an instrument that executes units.
// Contract
// - Listen address is primary address plus 32
// - Talk address is primary address plus 64
// - Switch address limited to 00 through 30
// - Execute message only after EOI or LF
// - Without REN refuse setting-altering commands
// - Queries evaluated in sequence within message
// - Several query answers returned in order
// - Name followed by question mark is query
// - Nothing pending: send all-ones byte with EOI
// - Settings-learn answer covers every programmable function
// - Settings-learn answer is accepted as input
// - Event query reports specific service cause
// - Help query lists commands alphabetically; the interpreter passes it to the instrument like any other query
// - Semicolon-separated commands executed in order
`timescale 1ns/1ps
module bmi_interp
  import bmi_pkg::*;
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic [4:0] addr_sw_in,
  input wire logic ren_in,
  input wire logic rx_valid_in,
  input wire bmi_rx_s rx_in,
  output logic rx_ready_out,
  output logic listen_out,
  output logic talk_out,
  output logic cmd_valid_out,
  output bmi_cmd_s cmd_out,
  output logic cmd_end_out,
  input wire logic cls_alters_in,
  output logic exec_out,
  input wire logic ans_valid_in,
  input wire logic [7:0] ans_byte_in,
  input wire logic done_in,
  output logic tx_valid_out,
  output bmi_tx_s tx_out,
  input wire logic tx_ready_in,
  output logic srq_out,
  output logic [6:0] event_code_out
);
  function automatic logic [7:0] bmi_addr(input logic [7:0] base, input logic [4:0] sw);
    logic [4:0] pa;
    pa = (sw > BMI_ADDR_MAX) ? BMI_ADDR_MAX : sw;
    return base + {3'h0, pa};
  endfunction

  function automatic logic [7:0] bmi_upper(input logic [7:0] c);
    return (c >= 8'h61 && c <= 8'h7A) ? c - 8'h20 : c;
  endfunction

  bmi_state_e state_q, state_d;
  logic listen_q, listen_d, talk_q, talk_d, rx_ready_q, rx_ready_d;
  logic [6:0] in_cnt_q, in_cnt_d, scan_q, scan_d, ulen_q, ulen_d;
  logic [6:0] out_cnt_q, out_cnt_d, tx_idx_q, tx_idx_d;
  logic qry_q, qry_d, dig_q, dig_d, spoke_q, spoke_d, from_buf_q, from_buf_d;
  logic [39:0] name_q, name_d;
  logic [2:0] name_n_q, name_n_d;
  logic cmd_valid_q, cmd_valid_d, end_q, end_d, exec_q, exec_d;
  bmi_cmd_s cmd_q, cmd_d;
  bmi_tx_s tx_q, tx_d;
  logic tx_valid_q, tx_valid_d, srq_q, srq_d;
  logic [6:0] ev_q, ev_d;
  logic in_we, out_we, take, data_take, term;
  logic [7:0] in_rd, out_rd, out_wdata, rx_byte;

  assign take = rx_valid_in && (rx_in.atn || rx_ready_q);
  assign data_take = take && !rx_in.atn && listen_q;
  assign term = data_take && (rx_in.eoi || rx_in.data == BMI_LF);
  assign rx_byte = bmi_upper(in_rd);

  bmi_byte_store u_in_store (
    .clk_in(clk_in),
    .we_in(in_we),
    .waddr_in(in_cnt_q[5:0]),
    .wdata_in(rx_in.data),
    .raddr_in(scan_q[5:0]),
    .rdata_out(in_rd)
  );

  bmi_byte_store u_out_store (
    .clk_in(clk_in),
    .we_in(out_we),
    .waddr_in(out_cnt_q[5:0]),
    .wdata_in(out_wdata),
    .raddr_in(tx_idx_q[5:0]),
    .rdata_out(out_rd)
  );

  always_comb begin
    state_d = state_q;
    listen_d = listen_q;
    talk_d = talk_q;
    in_cnt_d = in_cnt_q;
    scan_d = scan_q;
    ulen_d = ulen_q;
    qry_d = qry_q;
    name_d = name_q;
    name_n_d = name_n_q;
    dig_d = dig_q;
    out_cnt_d = out_cnt_q;
    tx_idx_d = tx_idx_q;
    tx_valid_d = tx_valid_q;
    tx_d = tx_q;
    spoke_d = spoke_q && talk_q;
    from_buf_d = from_buf_q;
    cmd_valid_d = 1'b0;
    cmd_d = cmd_q;
    end_d = 1'b0;
    exec_d = 1'b0;
    srq_d = srq_q;
    ev_d = ev_q;
    in_we = 1'b0;
    out_we = 1'b0;
    out_wdata = BMI_SEMI;
    if (take && rx_in.atn) begin
      if (rx_in.data == bmi_addr(BMI_LISTEN_BASE, addr_sw_in)) begin
        listen_d = 1'b1;
      end else if (rx_in.data == BMI_UNL) begin
        listen_d = 1'b0;
      end
      if (rx_in.data == bmi_addr(BMI_TALK_BASE, addr_sw_in)) begin
        talk_d = 1'b1;
      end else if (rx_in.data >= BMI_TALK_BASE && rx_in.data <= BMI_TALK_TOP) begin
        talk_d = 1'b0;
      end
    end
    // Fresh input discards answers nobody collected, so stale replies never leak out.
    if (data_take && in_cnt_q == 7'h00) begin
      out_cnt_d = 7'h00;
      tx_idx_d = 7'h00;
    end
    if (data_take && rx_in.data != BMI_LF) begin
      if (in_cnt_q < BMI_DEPTH) begin
        in_we = 1'b1;
        in_cnt_d = in_cnt_q + 7'h01;
      end else begin
        ev_d = BMI_EV_OVERRUN;
        srq_d = 1'b1;
      end
    end
    case (state_q)
      S_IDLE: begin
        if (term) begin
          state_d = S_SCAN;
          scan_d = 7'h00;
        end
      end
      S_SCAN: begin
        if (scan_q == in_cnt_q || in_rd == BMI_SEMI) begin
          if (scan_q != in_cnt_q) begin
            scan_d = scan_q + 7'h01;
          end
          if (ulen_q != 7'h00) begin
            end_d = 1'b1;
            cmd_d.query = qry_q;
            state_d = S_DECIDE;
          end else if (scan_q == in_cnt_q) begin
            state_d = S_IDLE;
            in_cnt_d = 7'h00;
          end
        end else begin
          scan_d = scan_q + 7'h01;
          ulen_d = ulen_q + 7'h01;
          cmd_valid_d = 1'b1;
          cmd_d.data = in_rd;
          cmd_d.query = 1'b0;
          if (in_rd != BMI_SPACE) begin
            qry_d = (in_rd == BMI_QMARK);
            if (name_n_q < BMI_NAME_LEN && in_rd != BMI_QMARK) begin
              name_d = {name_q[31:0], rx_byte};
              name_n_d = name_n_q + 3'h1;
            end
          end
        end
      end
      S_DECIDE: begin
        ulen_d = 7'h00;
        qry_d = 1'b0;
        name_d = 40'h0;
        name_n_d = 3'h0;
        if (qry_q && out_cnt_q != 7'h00 && out_cnt_q < BMI_DEPTH) begin
          out_we = 1'b1;
          out_cnt_d = out_cnt_q + 7'h01;
        end
        if (qry_q && name_n_q == BMI_NAME_LEN && name_q == BMI_EVENT_NAME) begin
          state_d = S_EVANS;
          dig_d = 1'b0;
        end else if (!qry_q && !ren_in && cls_alters_in) begin
          state_d = S_SCAN;
          ev_d = BMI_EV_LOCKED;
          srq_d = 1'b1;
        end else begin
          exec_d = 1'b1;
          state_d = S_RUN;
        end
      end
      S_RUN: begin
        if (ans_valid_in && out_cnt_q < BMI_DEPTH) begin
          out_we = 1'b1;
          out_wdata = ans_byte_in;
          out_cnt_d = out_cnt_q + 7'h01;
        end
        if (done_in) begin
          state_d = S_SCAN;
        end
      end
      S_EVANS: begin
        out_wdata = BMI_ZERO_CHAR + {1'b0, dig_q ? ev_q % 7'h0A : ev_q / 7'h0A};
        if (out_cnt_q < BMI_DEPTH) begin
          out_we = 1'b1;
          out_cnt_d = out_cnt_q + 7'h01;
        end
        dig_d = 1'b1;
        if (dig_q) begin
          state_d = S_SCAN;
          ev_d = BMI_EV_NONE;
          srq_d = 1'b0;
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
    if (tx_valid_q && tx_ready_in) begin
      tx_valid_d = 1'b0;
      if (tx_q.eoi) begin
        spoke_d = 1'b1;
        if (from_buf_q) begin
          out_cnt_d = 7'h00;
          tx_idx_d = 7'h00;
        end
      end else begin
        tx_idx_d = tx_idx_q + 7'h01;
      end
    end else if (talk_q && !tx_valid_q && !spoke_q && state_q == S_IDLE) begin
      tx_valid_d = 1'b1;
      if (out_cnt_q > tx_idx_q) begin
        tx_d.data = out_rd;
        tx_d.eoi = (tx_idx_q + 7'h01 == out_cnt_q);
        from_buf_d = 1'b1;
      end else begin
        tx_d.data = BMI_FILL;
        tx_d.eoi = 1'b1;
        from_buf_d = 1'b0;
      end
    end
    rx_ready_d = (state_d == S_IDLE);
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_q <= S_IDLE;
      listen_q <= 1'b0;
      talk_q <= 1'b0;
      rx_ready_q <= 1'b0;
      in_cnt_q <= 7'h00;
      scan_q <= 7'h00;
      ulen_q <= 7'h00;
      qry_q <= 1'b0;
      name_q <= 40'h0;
      name_n_q <= 3'h0;
      dig_q <= 1'b0;
      out_cnt_q <= 7'h00;
      tx_idx_q <= 7'h00;
      tx_valid_q <= 1'b0;
      tx_q <= '0;
      spoke_q <= 1'b0;
      from_buf_q <= 1'b0;
      cmd_valid_q <= 1'b0;
      cmd_q <= '0;
      end_q <= 1'b0;
      exec_q <= 1'b0;
      srq_q <= 1'b0;
      ev_q <= BMI_EV_NONE;
    end else begin
      state_q <= state_d;
      listen_q <= listen_d;
      talk_q <= talk_d;
      rx_ready_q <= rx_ready_d;
      in_cnt_q <= in_cnt_d;
      scan_q <= scan_d;
      ulen_q <= ulen_d;
      qry_q <= qry_d;
      name_q <= name_d;
      name_n_q <= name_n_d;
      dig_q <= dig_d;
      out_cnt_q <= out_cnt_d;
      tx_idx_q <= tx_idx_d;
      tx_valid_q <= tx_valid_d;
      tx_q <= tx_d;
      spoke_q <= spoke_d;
      from_buf_q <= from_buf_d;
      cmd_valid_q <= cmd_valid_d;
      cmd_q <= cmd_d;
      end_q <= end_d;
      exec_q <= exec_d;
      srq_q <= srq_d;
      ev_q <= ev_d;
    end
  end

  assign rx_ready_out = rx_ready_q;
  assign listen_out = listen_q;
  assign talk_out = talk_q;
  assign cmd_valid_out = cmd_valid_q;
  assign cmd_out = cmd_q;
  assign cmd_end_out = end_q;
  assign exec_out = exec_q;
  assign tx_valid_out = tx_valid_q;
  assign tx_out = tx_q;
  assign srq_out = srq_q;
  assign event_code_out = ev_q;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  sequence s_unit_end;
    end_q && state_q == S_DECIDE;
  endsequence

  AST_LISTEN_ADDR: assert property (take && rx_in.atn &&
    rx_in.data == bmi_addr(BMI_LISTEN_BASE, addr_sw_in) |=> listen_q)
    else $error("listen address not honoured");
  AST_TALK_ADDR: assert property (take && rx_in.atn &&
    rx_in.data == bmi_addr(BMI_TALK_BASE, addr_sw_in) |=> talk_q)
    else $error("talk address not honoured");
  AST_ADDR_RANGE: assert property (bmi_addr(BMI_LISTEN_BASE, addr_sw_in) <= 8'h3E)
    else $error("primary address above 30");
  AST_WAIT_TERM: assert property (state_q == S_IDLE && !term |=>
    state_q == S_IDLE && !cmd_valid_q)
    else $error("execution started without terminator");
  AST_LOCKED: assert property (s_unit_end ##0 (!qry_q && !ren_in && cls_alters_in)
    |=> !exec_q && state_q == S_SCAN && srq_q)
    else $error("setting change executed without remote enable");
  AST_EXEC_AFTER_END: assert property (exec_q |-> $past(end_q) && state_q == S_RUN)
    else $error("execution not tied to unit end");
  AST_QUERY_SEP: assert property (s_unit_end ##0 (qry_q && out_cnt_q != 7'h00 &&
    out_cnt_q < BMI_DEPTH) |=> out_cnt_q == $past(out_cnt_q) + 7'h01)
    else $error("answers not separated");
  AST_FILLER: assert property (talk_q && !tx_valid_q && !spoke_q && state_q == S_IDLE &&
    out_cnt_q == 7'h00 |=> tx_valid_q && tx_q.data == BMI_FILL && tx_q.eoi)
    else $error("filler byte missing");
  AST_LAST_EOI: assert property (tx_valid_q && from_buf_q &&
    tx_idx_q + 7'h01 == out_cnt_q |-> tx_q.eoi)
    else $error("no EOI on last answer byte");
  AST_EVENT_ANS: assert property (state_q == S_EVANS && !dig_q && out_cnt_q < 7'h3F |=>
    out_cnt_q == $past(out_cnt_q) + 7'h01 ##1 !srq_q && state_q == S_SCAN)
    else $error("event answer sequence broken");
endmodule // bmi_interp

// ### verilog/bmi_pkg.sv
// Constants, types and encodings shared by the bus message interpreter.
// Assumes a byte-level listener/talker handshake layer outside the block.
package bmi_pkg;
  localparam logic [6:0] BMI_DEPTH = 7'h40;
  localparam logic [4:0] BMI_ADDR_MAX = 5'h1E;
  localparam logic [7:0] BMI_LISTEN_BASE = 8'h20;
  localparam logic [7:0] BMI_TALK_BASE = 8'h40;
  localparam logic [7:0] BMI_TALK_TOP = 8'h5F;
  localparam logic [7:0] BMI_UNL = 8'h3F;
  localparam logic [7:0] BMI_LF = 8'h0A;
  localparam logic [7:0] BMI_SEMI = 8'h3B;
  localparam logic [7:0] BMI_QMARK = 8'h3F;
  localparam logic [7:0] BMI_SPACE = 8'h20;
  localparam logic [7:0] BMI_FILL = 8'hFF;
  localparam logic [7:0] BMI_ZERO_CHAR = 8'h30;
  localparam logic [39:0] BMI_EVENT_NAME = 40'h4556454E54;
  localparam logic [2:0] BMI_NAME_LEN = 3'h5;
  localparam logic [6:0] BMI_EV_NONE = 7'h00;
  localparam logic [6:0] BMI_EV_LOCKED = 7'h15;
  localparam logic [6:0] BMI_EV_OVERRUN = 7'h16;

  typedef struct packed {
    logic [7:0] data;
    logic eoi;
    logic atn;
  } bmi_rx_s;

  typedef struct packed {
    logic [7:0] data;
    logic eoi;
  } bmi_tx_s;

  typedef struct packed {
    logic [7:0] data;
    logic query;
  } bmi_cmd_s;

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_SCAN = 5'b00010,
    S_DECIDE = 5'b00100,
    S_RUN = 5'b01000,
    S_EVANS = 5'b10000
  } bmi_state_e;
endpackage
